// ===== rtl/ccc_consts.svh
// Constants of the capture/compare channel block: offsets, fields, reset values, timing.
`ifndef CCC_CONSTS_SVH
`define CCC_CONSTS_SVH

// Register byte offsets on the 8-bit APB address.
`define CCC_MODE_PAGE 4'h0
`define CCC_VAL_PAGE 2'h1
`define CCC_OFF_TIMER_A 8'h10
`define CCC_OFF_TIMER_B 8'h14
`define CCC_OFF_TCTRL 8'h18
`define CCC_OFF_TFLAG 8'h1C
`define CCC_OFF_CFLAG 8'h20
`define CCC_OFF_CIRQEN 8'h24
`define CCC_OFF_PDIR 8'h28
`define CCC_OFF_PLATCH 8'h2C
`define CCC_OFF_PPIN 8'h30

// Channel field layout inside a mode control word.
`define CCC_FLD_W 4

// Reset values.
`define CCC_RST_WORD 16'h0000
`define CCC_RST_BYTE 8'h00
`define CCC_RST_DONE 16'hFFFF

// Timing: timer prescale in clocks, last scan step, timer wrap value.
`define CCC_TIMER_DIV 8
`define CCC_SCAN_LAST 3'h7
`define CCC_TIMER_MAX 16'hFFFF

`endif

// ===== rtl/ccc_pkg.sv
// Types shared by the capture/compare channel block.
package ccc_pkg;

	// Channel operating modes.
	typedef enum logic [2:0] {
		CCC_OFF = 3'h0,
		CCC_CAP_RISE = 3'h1,
		CCC_CAP_FALL = 3'h2,
		CCC_CAP_BOTH = 3'h3,
		CCC_CMP0 = 3'h4,
		CCC_CMP1 = 3'h5,
		CCC_CMP2 = 3'h6,
		CCC_CMP3 = 3'h7
	} ccc_mode_t;

	// One channel nibble of a mode control word.
	typedef struct packed {
		logic sel;
		ccc_mode_t mode;
	} ccc_chan_cfg_t;

	// Timer control word.
	typedef struct packed {
		logic [1:0] irq_en;
		logic [1:0] run;
	} ccc_tctrl_t;

endpackage

// ===== rtl/ccc_top.sv
// Sixteen capture/compare channels on two up-counting timers, with an APB register slave.
`timescale 1ns/1ps
`default_nettype none
`include "ccc_consts.svh"

module ccc_top
	import ccc_pkg::*;
#(
	parameter int unsigned TIMER_DIV = `CCC_TIMER_DIV
)
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Channel pins: 0-3 serve channels 16-19, 4-7 serve channels 24-27.
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	// Service requests.
	output logic [1:0] timer_irq,
	output logic [7:0] chan_irq,
	output logic adc_trigger
);

	localparam logic [15:0] DIV_LAST = 16'(TIMER_DIV - 1);

	// Returns the configuration nibble of channel q within a mode control word.
	function automatic ccc_chan_cfg_t cfg_of(input logic [15:0] word, input logic [1:0] q);
		cfg_of = ccc_chan_cfg_t'(word[q * `CCC_FLD_W +: `CCC_FLD_W]);
	endfunction

	// Sticky flag update; a set in the same cycle as a clear wins.
	function automatic logic [15:0] flag_next(input logic [15:0] cur, input logic [15:0] set,
		input logic [15:0] clr);
		flag_next = set | (cur & ~clr);
	endfunction

	logic [15:0] mode_ctrl [4];
	logic [15:0] cc_value [16];
	logic [15:0] timer_q [2];
	ccc_tctrl_t tctrl;
	logic [1:0] tflag;
	logic [15:0] cflag, cirq_en, done, lock;
	logic [7:0] pdir, platch, filt, prev_lvl;
	logic [7:0] sync1, sync2, sync3;
	logic [2:0] step;
	logic [15:0] div_cnt;
	logic [31:0] rd_mux;

	// Bus decode.
	wire acc = psel & penable;
	wire setup = psel & ~penable;
	wire aligned = paddr[1:0] == 2'h0;
	wire hit_mode = aligned & (paddr[7:4] == `CCC_MODE_PAGE);
	wire hit_val = aligned & (paddr[7:6] == `CCC_VAL_PAGE);
	wire hit_one = (paddr == `CCC_OFF_TIMER_A) | (paddr == `CCC_OFF_TIMER_B)
		| (paddr == `CCC_OFF_TCTRL) | (paddr == `CCC_OFF_TFLAG) | (paddr == `CCC_OFF_CFLAG)
		| (paddr == `CCC_OFF_CIRQEN) | (paddr == `CCC_OFF_PDIR) | (paddr == `CCC_OFF_PLATCH)
		| (paddr == `CCC_OFF_PPIN);
	wire addr_ok = hit_mode | hit_val | hit_one;
	wire wr_en = acc & pwrite & addr_ok;
	wire lwr = wr_en & (paddr == `CCC_OFF_PLATCH);
	wire tflag_clr = wr_en & (paddr == `CCC_OFF_TFLAG);
	wire cflag_clr = wr_en & (paddr == `CCC_OFF_CFLAG);

	// Zero-wait slave: read data is latched in setup, so the answer is ready in access.
	assign pready = acc;
	assign pslverr = acc & ~addr_ok;

	// Timer events; a software write blocks the increment of the same cycle.
	logic [1:0] twr, tinc, ovf, tchg;
	assign twr[0] = wr_en & (paddr == `CCC_OFF_TIMER_A);
	assign twr[1] = wr_en & (paddr == `CCC_OFF_TIMER_B);
	assign tinc = tctrl.run & {2{div_cnt == DIV_LAST}} & ~twr;
	assign ovf = tinc & {timer_q[1] == `CCC_TIMER_MAX, timer_q[0] == `CCC_TIMER_MAX};
	assign tchg = tinc | twr;

	// Per-channel configuration and scan slot.
	ccc_chan_cfg_t cfgc [16];
	logic [15:0] chan_hit, chan_cap, chan_ev, vwr, next_done, next_lock;
	logic [15:0] tval_c [16];
	logic [1:0] cap, hit;
	logic [3:0] slot_ch [2];
	ccc_chan_cfg_t slot_cfg [2];
	logic [15:0] slot_tval [2];
	logic [7:0] pin_lvl, pin_scan, pset, pclr, ptog, next_latch;

	// Each scan step serves channel step and channel step+8.
	for (genvar s = 0; s < 2; s++)
	begin : g_slot
		assign slot_ch[s] = {1'(s), step};
		assign slot_cfg[s] = cfgc[slot_ch[s]];
		assign slot_tval[s] = timer_q[slot_cfg[s].sel];
		wire slot_lvl = pin_lvl[{1'(s), step[1:0]}];
		wire slot_prev = prev_lvl[{1'(s), step[1:0]}];
		wire rise = slot_lvl & ~slot_prev;
		wire fall = ~slot_lvl & slot_prev;
		// Only channels with bit 2 clear own a pin, so only they can capture.
		assign cap[s] = ~step[2] & (((slot_cfg[s].mode == CCC_CAP_RISE) & rise)
			| ((slot_cfg[s].mode == CCC_CAP_FALL) & fall)
			| ((slot_cfg[s].mode == CCC_CAP_BOTH) & (rise | fall)));
		// Mode bit 2 marks compare; modes 110 and 111 are also held off by the period lock.
		assign hit[s] = slot_cfg[s].mode[2] & (cc_value[slot_ch[s]] == slot_tval[s])
			& ~done[slot_ch[s]] & ~(slot_cfg[s].mode[1] & lock[slot_ch[s]]);
	end

	// Channel-wide decode of events, storage writes and compare guards.
	for (genvar c = 0; c < 16; c++)
	begin : g_chan
		assign cfgc[c] = cfg_of(mode_ctrl[c / 4], 2'(c % 4));
		assign tval_c[c] = timer_q[cfgc[c].sel];
		wire scan_c = step == 3'(c % 8);
		assign chan_hit[c] = scan_c & hit[c / 8];
		assign chan_cap[c] = scan_c & cap[c / 8];
		assign chan_ev[c] = chan_hit[c] | chan_cap[c];
		assign vwr[c] = wr_en & hit_val & (paddr[5:2] == 4'(c));
		// A timer change re-arms the channel; the match that saw the old count loses.
		assign next_done[c] = tchg[cfgc[c].sel] ? 1'h0 : (chan_hit[c] ? 1'h1 : done[c]);
		assign next_lock[c] = ovf[cfgc[c].sel] ? 1'h0
			: ((chan_hit[c] & cfgc[c].mode[1]) ? 1'h1 : lock[c]);
	end

	// Pin side: edge source, and latch actions from the owning channel or its pair.
	for (genvar p = 0; p < 8; p++)
	begin : g_pin
		localparam int C = (p < 4) ? p : p + 4;
		assign pin_lvl[p] = pdir[p] ? platch[p] : filt[p];
		assign pin_scan[p] = step == 3'(p % 4);
		assign pset[p] = chan_hit[C] & (cfgc[C].mode == CCC_CMP3);
		assign pclr[p] = ovf[cfgc[C].sel] & (cfgc[C].mode == CCC_CMP3);
		if (p < 4)
		begin : g_pair
			wire pair_on = (cfgc[C].mode == CCC_CMP1) & (cfgc[C + 8].mode == CCC_CMP0);
			// Both halves of a pair matching at once still toggle the pin only once.
			assign ptog[p] = (chan_hit[C] & (cfgc[C].mode == CCC_CMP1))
				| (chan_hit[C + 8] & pair_on);
		end
		else
		begin : g_single
			assign ptog[p] = chan_hit[C] & (cfgc[C].mode == CCC_CMP1);
		end
		// Coinciding set and clear leave the pin as it is; the flag is still raised.
		assign next_latch[p] = (pset[p] & pclr[p]) ? platch[p]
			: pset[p] ? 1'h1 : pclr[p] ? 1'h0 : ptog[p] ? ~platch[p] : platch[p];
	end

	assign pin_out = platch;
	assign pin_oe = pdir;
	assign timer_irq = tflag & tctrl.irq_en;
	assign chan_irq = {cflag[11:8], cflag[3:0]} & {cirq_en[11:8], cirq_en[3:0]};

	// Read data selection.
	always_comb
	begin
		rd_mux = 32'h0;
		if (hit_mode)
			rd_mux = {16'h0, mode_ctrl[paddr[3:2]]};
		else if (hit_val)
			rd_mux = {16'h0, cc_value[paddr[5:2]]};
		else
		begin
			case (paddr)
				`CCC_OFF_TIMER_A: rd_mux = {16'h0, timer_q[0]};
				`CCC_OFF_TIMER_B: rd_mux = {16'h0, timer_q[1]};
				`CCC_OFF_TCTRL: rd_mux = {28'h0, tctrl};
				`CCC_OFF_TFLAG: rd_mux = {30'h0, tflag};
				`CCC_OFF_CFLAG: rd_mux = {16'h0, cflag};
				`CCC_OFF_CIRQEN: rd_mux = {16'h0, cirq_en};
				`CCC_OFF_PDIR: rd_mux = {24'h0, pdir};
				`CCC_OFF_PLATCH: rd_mux = {24'h0, platch};
				`CCC_OFF_PPIN: rd_mux = {24'h0, filt};
				default: rd_mux = 32'h0;
			endcase
		end
	end

	// Read data register; sampled in setup so the access cycle already holds it.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		else if (setup & ~pwrite)
			prdata <= rd_mux;
	end

	// Pin synchroniser and filter: a level counts once stages two and three agree.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1 <= `CCC_RST_BYTE;
			sync2 <= `CCC_RST_BYTE;
			sync3 <= `CCC_RST_BYTE;
			filt <= `CCC_RST_BYTE;
		end
		else
		begin
			sync1 <= pin_in;
			sync2 <= sync1;
			sync3 <= sync2;
			filt <= (sync2 & sync3) | (filt & (sync2 ^ sync3));
		end
	end

	// Last level seen per pin, refreshed when its channel is scanned.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prev_lvl <= `CCC_RST_BYTE;
		else
			prev_lvl <= (pin_lvl & pin_scan) | (prev_lvl & ~pin_scan);
	end

	// Scan step counter and shared timer prescaler, both free running.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			step <= 3'h0;
			div_cnt <= 16'h0;
		end
		else
		begin
			step <= step + 3'h1;
			div_cnt <= (div_cnt == DIV_LAST) ? 16'h0 : div_cnt + 16'h1;
		end
	end

	// Timers: software write has priority over the increment.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			timer_q[0] <= `CCC_RST_WORD;
			timer_q[1] <= `CCC_RST_WORD;
		end
		else
		begin
			for (int t = 0; t < 2; t++)
				timer_q[t] <= twr[t] ? pwdata[15:0] : timer_q[t] + {15'h0, tinc[t]};
		end
	end

	// Control registers written by software.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int m = 0; m < 4; m++)
				mode_ctrl[m] <= `CCC_RST_WORD;
			tctrl <= ccc_tctrl_t'(4'h0);
			cirq_en <= `CCC_RST_WORD;
			pdir <= `CCC_RST_BYTE;
		end
		else if (wr_en)
		begin
			if (hit_mode)
				mode_ctrl[paddr[3:2]] <= pwdata[15:0];
			if (paddr == `CCC_OFF_TCTRL)
				tctrl <= ccc_tctrl_t'(pwdata[3:0]);
			if (paddr == `CCC_OFF_CIRQEN)
				cirq_en <= pwdata[15:0];
			if (paddr == `CCC_OFF_PDIR)
				pdir <= pwdata[7:0];
		end
	end

	// Value registers: a capture beats a software write of the same cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int v = 0; v < 16; v++)
				cc_value[v] <= `CCC_RST_WORD;
		end
		else
		begin
			for (int v = 0; v < 16; v++)
				if (chan_cap[v])
					cc_value[v] <= tval_c[v];
				else if (vwr[v])
					cc_value[v] <= pwdata[15:0];
		end
	end

	// Flags are write-one-to-clear and sticky; compare guards start disarmed.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tflag <= 2'h0;
			cflag <= `CCC_RST_WORD;
			done <= `CCC_RST_DONE;
			lock <= `CCC_RST_WORD;
			adc_trigger <= 1'h0;
		end
		else
		begin
			tflag <= 2'(flag_next({14'h0, tflag}, {14'h0, ovf}, {14'h0,
				pwdata[1:0] & {2{tflag_clr}}}));
			cflag <= flag_next(cflag, chan_ev, pwdata[15:0] & {16{cflag_clr}});
			done <= next_done;
			lock <= next_lock;
			adc_trigger <= chan_ev[11];
		end
	end

	// Output latch: a software write wins over any hardware change.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			platch <= `CCC_RST_BYTE;
		else
			platch <= lwr ? pwdata[7:0] : next_latch;
	end

	// Checks.
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Notes whether any timer has changed since reset.
	logic seen_chg;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			seen_chg <= 1'h0;
		else if (|tchg)
			seen_chg <= 1'h1;
	end

	sequence toggle_cause;
		ptog[0] && !pset[0] && !pclr[0] && !lwr;
	endsequence

	sequence pair_cause;
		g_pin[0].g_pair.pair_on && chan_hit[8] && !lwr;
	endsequence

	ovf_flag_a: assert property (ovf[0] |=> tflag[0])
		else $error("timer_a overflow did not set its flag");
	cap_timer_b_a: assert property (cap[0] && slot_cfg[0].sel
		|=> cc_value[$past(slot_ch[0])] == $past(timer_q[1]))
		else $error("capture did not take timer_b");
	off_quiet_a: assert property ((slot_cfg[0].mode == CCC_OFF) |-> !cap[0] && !hit[0])
		else $error("disabled channel produced an event");
	rise_only_a: assert property (cap[0] && (slot_cfg[0].mode == CCC_CAP_RISE)
		|-> g_slot[0].slot_lvl && !g_slot[0].slot_prev)
		else $error("rising capture without rising edge");
	cap_value_a: assert property (cap[1] |=> cc_value[$past(slot_ch[1])] == $past(slot_tval[1]))
		else $error("capture stored wrong count");
	cap_flag_a: assert property (cap[0] |=> cflag[$past(slot_ch[0])])
		else $error("capture did not set the event flag");
	scan_order_a: assert property (step == `CCC_SCAN_LAST |=> step == 3'h0 ##7 step == 3'h7)
		else $error("scan sequence is not eight steps");
	cmp_flag_a: assert property (hit[1] |=> cflag[$past(slot_ch[1])])
		else $error("compare match did not set the event flag");
	cmp_once_a: assert property (hit[0] && !(|tchg) ##1 !(|tchg) [*7] |=> !hit[0])
		else $error("compare guard not held after match");
	reset_quiet_a: assert property (!seen_chg |-> !hit[0] && !hit[1])
		else $error("compare event before any timer change");
	cmp0_pin_a: assert property (chan_hit[8] && (cfgc[8].mode == CCC_CMP0) && !lwr
		|=> platch[4] == $past(platch[4]))
		else $error("mode 100 disturbed the pin latch");
	pair_toggle_a: assert property (pair_cause |=> platch[0] != $past(platch[0]))
		else $error("paired match did not toggle the bank 1 pin");
	toggle_pin_a: assert property (toggle_cause |=> platch[0] == !$past(platch[0]))
		else $error("mode 101 did not toggle the latch");
	period_lock_a: assert property (hit[0] && (slot_cfg[0].mode == CCC_CMP2) && !(|ovf)
		|=> lock[$past(slot_ch[0])])
		else $error("mode 110 not locked after match");
	set_clear_a: assert property (pclr[1] && !pset[1] && !lwr |=> !platch[1])
		else $error("mode 111 pin not cleared on overflow");
	adc_pulse_a: assert property (chan_ev[11] |=> adc_trigger)
		else $error("channel 27 event did not trigger the converter");
	sw_wins_a: assert property (lwr |=> platch == $past(pwdata[7:0]))
		else $error("software latch write lost");
	flag_hold_a: assert property (cflag[0] && !cflag_clr |=> cflag[0])
		else $error("event flag dropped without a clear");

endmodule

`default_nettype wire

// ===== verification/capture_compare_channels_tb_top.sv
// Self-checking bench for the capture/compare channel block.
`timescale 1ns/1ps
`default_nettype none
`include "ccc_consts.svh"

module capture_compare_channels_tb_top
	import ccc_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] pin_in;
	logic [7:0] pin_out;
	logic [7:0] pin_oe;
	logic [7:0] ext_level = 8'h00;
	logic [1:0] timer_irq;
	logic [7:0] chan_irq;
	logic adc_trigger;
	logic [31:0] rdat;
	logic rerr;
	int err_count = 0;
	int checks = 0;
	int cyc = 0;
	int adc_cnt = 0;

	// Clock of 100 ns period.
	always #50 pclk = ~pclk;

	ccc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.timer_irq(timer_irq), .chan_irq(chan_irq), .adc_trigger(adc_trigger));

	ccc_pin_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
		.pin_in(pin_in));

	// Counts converter trigger pulses and cuts a hung run short.
	always @(posedge pclk)
	begin
		if (adc_trigger === 1'b1)
			adc_cnt <= adc_cnt + 1;
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_count++;
			close_out();
		end
	end

	task automatic close_out();
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic clks(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// One APB transfer; the request stands until pready is sampled high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		chk(name, rdat, exp);
	endtask

	// Compare mode on a timer never touched since reset stays silent; registers are storage.
	task automatic t_reset_and_storage();
		rchk("mode word reset", 8'h04, 32'h00000000);
		wr(8'h04, 32'h00000040);
		clks(30);
		rchk("no event before timer change", `CCC_OFF_CFLAG, 32'h00000000);
		wr(8'h50, 32'hFFFFBEEF);
		rchk("plain storage", 8'h50, 32'h0000BEEF);
		apb(1'b0, 8'hFC, 32'h00000000);
		chk("unmapped error", {31'h0, rerr}, 32'h00000001);
		chk("unmapped data", rdat, 32'h00000000);
	endtask

	// Pin edges with stopped timers, each edge kind and both timer selections.
	task automatic t_capture();
		wr(`CCC_OFF_TIMER_A, 32'h00000100);
		wr(`CCC_OFF_TIMER_B, 32'h00000200);
		wr(8'h00, 32'h00003291);
		wr(`CCC_OFF_CIRQEN, 32'h00000F01);
		ext_level <= 8'h0F;
		clks(24);
		rchk("rise on timer_a", 8'h40, 32'h00000100);
		rchk("rise on timer_b", 8'h44, 32'h00000200);
		rchk("fall mode ignores rise", 8'h48, 32'h00000000);
		rchk("both edges rise", 8'h4C, 32'h00000100);
		rchk("capture flags", `CCC_OFF_CFLAG, 32'h0000000B);
		chk("pin request map", {24'h0, chan_irq}, 32'h00000001);
		wr(`CCC_OFF_CFLAG, 32'h0000000F);
		wr(`CCC_OFF_TIMER_A, 32'h00000300);
		ext_level <= 8'h00;
		clks(24);
		rchk("fall capture", 8'h48, 32'h00000300);
		rchk("both edges fall", 8'h4C, 32'h00000300);
		rchk("rise mode ignores fall", 8'h40, 32'h00000100);
		rchk("fall flags", `CCC_OFF_CFLAG, 32'h0000000C);
		wr(`CCC_OFF_CFLAG, 32'h0000FFFF);
	endtask

	// A software latch change on an output pin captures and fires the converter trigger.
	task automatic t_latch_capture();
		wr(8'h08, 32'h00001000);
		wr(`CCC_OFF_PDIR, 32'h00000080);
		adc_cnt = 0;
		wr(`CCC_OFF_PLATCH, 32'h00000080);
		clks(24);
		rchk("latch capture", 8'h6C, 32'h00000300);
		rchk("latch capture flag", `CCC_OFF_CFLAG, 32'h00000800);
		chk("converter trigger", adc_cnt, 32'h00000001);
		chk("pin drive", {24'h0, pin_out & pin_oe}, 32'h00000080);
		wr(`CCC_OFF_CFLAG, 32'h0000FFFF);
	endtask

	// Equal values on two channels, mode 100 re-armed by a timer write against mode 110 held by the period lock.
	task automatic t_compare_once();
		wr(8'h58, 32'h00000050);
		wr(8'h5C, 32'h00000050);
		wr(8'h04, 32'h00004640);
		wr(`CCC_OFF_TIMER_A, 32'h00000050);
		clks(20);
		rchk("equal values both flag", `CCC_OFF_CFLAG, 32'h000000C0);
		wr(`CCC_OFF_CFLAG, 32'h000000C0);
		clks(20);
		rchk("no repeat on same value", `CCC_OFF_CFLAG, 32'h00000000);
		wr(`CCC_OFF_TIMER_A, 32'h00000050);
		clks(20);
		rchk("rewrite rearms mode 100 only", `CCC_OFF_CFLAG, 32'h00000080);
		wr(`CCC_OFF_CFLAG, 32'h0000FFFF);
	endtask

	// Toggle and set-then-overflow-clear output actions, with the overflow request.
	task automatic t_compare_pins();
		wr(8'h40, 32'h00000060);
		wr(8'h44, 32'h0000FFFE);
		wr(8'h00, 32'h00000075);
		wr(`CCC_OFF_PDIR, 32'h00000083);
		wr(`CCC_OFF_TIMER_A, 32'h00000060);
		clks(20);
		rchk("toggle latch", `CCC_OFF_PLATCH, 32'h00000081);
		chk("toggle pin", {24'h0, pin_out}, 32'h00000081);
		wr(`CCC_OFF_TIMER_A, 32'h0000FFFE);
		clks(20);
		rchk("set on match", `CCC_OFF_PLATCH, 32'h00000083);
		wr(`CCC_OFF_TCTRL, 32'h00000005);
		clks(40);
		wr(`CCC_OFF_TCTRL, 32'h00000004);
		rchk("clear on overflow", `CCC_OFF_PLATCH, 32'h00000081);
		rchk("overflow flag", `CCC_OFF_TFLAG, 32'h00000001);
		chk("overflow request", {30'h0, timer_irq}, 32'h00000001);
		wr(`CCC_OFF_TCTRL, 32'h00000000);
		chk("request masked", {30'h0, timer_irq}, 32'h00000000);
		rchk("flag kept while masked", `CCC_OFF_TFLAG, 32'h00000001);
	endtask

	// A bank 2 mode 100 match toggles the bank 1 pin; a joint match toggles it only once.
	task automatic t_pair();
		wr(`CCC_OFF_CFLAG, 32'h0000FFFF);
		wr(8'h60, 32'h00000070);
		wr(8'h08, 32'h00001004);
		wr(`CCC_OFF_TIMER_A, 32'h00000070);
		clks(20);
		rchk("pair match toggles bank 1 pin", `CCC_OFF_PLATCH, 32'h00000080);
		rchk("pair flags own channel", `CCC_OFF_CFLAG, 32'h00000100);
		wr(`CCC_OFF_CFLAG, 32'h0000FFFF);
		wr(8'h60, 32'h00000060);
		wr(`CCC_OFF_TIMER_A, 32'h00000060);
		clks(20);
		rchk("joint match toggles once", `CCC_OFF_PLATCH, 32'h00000081);
		rchk("joint match flags both", `CCC_OFF_CFLAG, 32'h00000101);
	endtask

	// Reset for 16 clocks, then the scenarios in order.
	initial
	begin
		clks(16);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset_and_storage();
		t_capture();
		t_latch_capture();
		t_compare_once();
		t_compare_pins();
		t_pair();
		close_out();
	end

endmodule
`default_nettype wire

// ===== verification/ccc_pin_model.sv
// Far-side pin model: resolves each channel pin from the device drive and the outside source.
`timescale 1ns/1ps
`default_nettype none

module ccc_pin_model
(
	// Device side of the pins.
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	// Outside signal source.
	input wire logic [7:0] ext_level,
	// Level seen back at the device.
	output logic [7:0] pin_in
);

	// A driven pin shows the latch; otherwise the outside source owns the wire.
	// The source must be released by software clearing the direction bit first.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);

endmodule
`default_nettype wire
